// File: hw/cxp_pkg.sv
// Purpose: shared constants for the external configuration space port
// Assumes: single user clock at 125 MHz
// Notes:   register ranges and the response timeout live here
package cxp_pkg;
  localparam int          CXP_REG_W        = 10;
  localparam int          CXP_FN_W         = 8;
  localparam int          CXP_DATA_W       = 32;
  localparam int          CXP_BE_W         = 4;
  // legacy extended window
  localparam logic [9:0]  CXP_LEG_LO       = 10'h0b0;
  localparam logic [9:0]  CXP_LEG_HI       = 10'h0bf;
  // extended window
  localparam logic [9:0]  CXP_EXT_LO       = 10'h120;
  localparam logic [9:0]  CXP_EXT_HI       = 10'h13f;
  // response wait, in user clock cycles
  localparam int          CXP_TIMEOUT_CYC  = 262144;
  localparam int          CXP_TMO_W        = 19;
  localparam logic [31:0] CXP_AUTO_DATA    = 32'h0000_0000;
  typedef enum logic [1:0] {CXP_IDLE, CXP_WAIT, CXP_DONE} cxp_state_t;
endpackage

// File: hw/cxp_port.sv
// Purpose: user-side configuration extend port of a link endpoint
// Assumes: link side delivers decoded config requests as one-cycle strobes
// Notes:   one outstanding read; later reads during a wait are held off
//
// Notes on behaviour
// R01: every link config read gives a one-cycle read strobe with register and function
// R02: registers 0xb0-0xbf legacy extended, 0x120-0x13f extended, both external
// R03: user answers only reads inside the two external ranges
// R04: writes in external ranges present register, function, data, enables with strobe; a write in the same cycle as a taken read gets no strobe
// R05: strobes only produced when the extended space option is enabled
// R06: ten-bit register number valid while either strobe is high
// R07: eight-bit function number valid while either strobe is high
// R08: thirty-two-bit write data valid while write strobe is high
// R09: four byte enables, one per write data byte lane
// R10: user read data and valid sampled on edges after the read strobe
// R11: no valid within 262144 cycles means core completes with zero data
// R12: after auto response user drops its pending answer, never asserts valid
// R13: user asserts valid at most once per read, one read outstanding
`timescale 1ns/10ps
`default_nettype none
module cxp_port
  import cxp_pkg::*;
#(
  parameter int TIMEOUT_CYC = CXP_TIMEOUT_CYC
)(
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst,
  input  wire logic                  i_ext_space_en,
  // requests decoded from the link
  input  wire logic                  i_lnk_rd_req,
  input  wire logic                  i_lnk_wr_req,
  input  wire logic [CXP_REG_W-1:0]  i_lnk_reg_num,
  input  wire logic [CXP_FN_W-1:0]   i_lnk_fn_num,
  input  wire logic [CXP_DATA_W-1:0] i_lnk_wr_data,
  input  wire logic [CXP_BE_W-1:0]   i_lnk_wr_be,
  output logic                       o_lnk_rd_ready,
  output logic                       o_lnk_cpl_valid,
  output logic [CXP_DATA_W-1:0]      o_lnk_cpl_data,
  output logic                       o_lnk_cpl_auto,
  // user application side
  output logic                       o_rd_received,
  output logic                       o_wr_received,
  output logic [CXP_REG_W-1:0]       o_reg_num,
  output logic [CXP_FN_W-1:0]        o_fn_num,
  output logic [CXP_DATA_W-1:0]      o_wr_data,
  output logic [CXP_BE_W-1:0]        o_wr_be,
  input  wire logic [CXP_DATA_W-1:0] i_rd_data,
  input  wire logic                  i_rd_data_valid
);

  cxp_state_t            state_r;
  logic [CXP_TMO_W-1:0]  tmo_cnt_r;
  logic                  reg_ext;
  logic                  rd_take;
  logic                  wr_take;
  logic                  tmo_hit;

  ////////////////////////////////////////////////////////////////////////
  // address classing
  always_comb
  begin
    reg_ext = ((i_lnk_reg_num >= CXP_LEG_LO) && (i_lnk_reg_num <= CXP_LEG_HI)) // R02
           || ((i_lnk_reg_num >= CXP_EXT_LO) && (i_lnk_reg_num <= CXP_EXT_HI)); // R02
  end

  // a read is only taken while idle, so one stays outstanding
  assign o_lnk_rd_ready = (state_r == CXP_IDLE);
  assign rd_take = i_lnk_rd_req && o_lnk_rd_ready && i_ext_space_en; // R01 R05
  assign wr_take = i_lnk_wr_req && reg_ext && i_ext_space_en; // R04 R05
  assign tmo_hit = (tmo_cnt_r == CXP_TMO_W'(TIMEOUT_CYC - 1));

  ////////////////////////////////////////////////////////////////////////
  // strobes and request fields toward the user
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_rd_received <= 1'b0;
      o_wr_received <= 1'b0;
      o_reg_num     <= '0;
      o_fn_num      <= '0;
      o_wr_data     <= '0;
      o_wr_be       <= '0;
    end
    else
    begin
      o_rd_received <= rd_take; // R01
      o_wr_received <= wr_take && !rd_take; // R04
      if (rd_take || wr_take)
      begin
        o_reg_num <= i_lnk_reg_num; // R06
        o_fn_num  <= i_lnk_fn_num; // R07
      end
      if (wr_take && !rd_take)
      begin
        o_wr_data <= i_lnk_wr_data; // R08
        o_wr_be   <= i_lnk_wr_be; // R09
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read wait machine; out-of-range reads still time out with zero data
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      state_r   <= CXP_IDLE;
      tmo_cnt_r <= '0;
    end
    else
    begin
      unique case (state_r)
        CXP_IDLE:
        begin
          tmo_cnt_r <= '0;
          if (rd_take)
            state_r <= CXP_WAIT;
        end
        CXP_WAIT:
        begin
          if (i_rd_data_valid || tmo_hit) // R10 R11
            state_r <= CXP_DONE;
          tmo_cnt_r <= tmo_cnt_r + 1'b1;
        end
        CXP_DONE:
          state_r <= CXP_IDLE;
        default:
          state_r <= CXP_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // completion back to the link
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_lnk_cpl_valid <= 1'b0;
      o_lnk_cpl_data  <= '0;
      o_lnk_cpl_auto  <= 1'b0;
    end
    else
    begin
      o_lnk_cpl_valid <= 1'b0;
      o_lnk_cpl_auto  <= 1'b0;
      if (state_r == CXP_WAIT && i_rd_data_valid)
      begin
        o_lnk_cpl_valid <= 1'b1;
        o_lnk_cpl_data  <= i_rd_data; // R10
      end
      else if (state_r == CXP_WAIT && tmo_hit)
      begin
        o_lnk_cpl_valid <= 1'b1;
        o_lnk_cpl_data  <= CXP_AUTO_DATA; // R11
        o_lnk_cpl_auto  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_rd_in;
    rd_take;
  endsequence
  sequence s_rd_strobe;
    o_rd_received ##1 !o_rd_received;
  endsequence

  property p_rd_pulse;
    @(posedge i_mclk) disable iff (i_rst) s_rd_in |=> s_rd_strobe;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe not one cycle"); // R01

  property p_wr_range;
    @(posedge i_mclk) disable iff (i_rst) o_wr_received |->
      ((o_reg_num >= CXP_LEG_LO && o_reg_num <= CXP_LEG_HI) ||
       (o_reg_num >= CXP_EXT_LO && o_reg_num <= CXP_EXT_HI));
  endproperty
  a_wr_range: assert property (p_wr_range) else $error("write strobe outside ranges"); // R02

  property p_wr_fields;
    @(posedge i_mclk) disable iff (i_rst) wr_take && !rd_take |=>
      o_wr_received && o_wr_data == $past(i_lnk_wr_data) && o_wr_be == $past(i_lnk_wr_be);
  endproperty
  a_wr_fields: assert property (p_wr_fields) else $error("write fields wrong"); // R04

  property p_en_gate;
    @(posedge i_mclk) disable iff (i_rst) !i_ext_space_en |=> !o_rd_received && !o_wr_received;
  endproperty
  a_en_gate: assert property (p_en_gate) else $error("strobe while disabled"); // R05

  property p_reg_num;
    @(posedge i_mclk) disable iff (i_rst) (rd_take || wr_take) |=>
      o_reg_num == $past(i_lnk_reg_num) && o_fn_num == $past(i_lnk_fn_num);
  endproperty
  a_reg_num: assert property (p_reg_num) else $error("register or function wrong"); // R06

  property p_fn_hold;
    @(posedge i_mclk) disable iff (i_rst) !(rd_take || wr_take) |=> $stable(o_fn_num);
  endproperty
  a_fn_hold: assert property (p_fn_hold) else $error("function number moved"); // R07

  property p_user_data;
    @(posedge i_mclk) disable iff (i_rst) (state_r == CXP_WAIT && i_rd_data_valid) |=>
      o_lnk_cpl_valid && !o_lnk_cpl_auto && o_lnk_cpl_data == $past(i_rd_data);
  endproperty
  a_user_data: assert property (p_user_data) else $error("user data not forwarded"); // R10

  property p_auto_zero;
    @(posedge i_mclk) disable iff (i_rst) o_lnk_cpl_auto |->
      o_lnk_cpl_valid && o_lnk_cpl_data == CXP_AUTO_DATA && $past(tmo_cnt_r) == CXP_TMO_W'(TIMEOUT_CYC - 1);
  endproperty
  a_auto_zero: assert property (p_auto_zero) else $error("auto response wrong"); // R11

  // auto reply only when the user stayed silent at that edge
  property p_auto_quiet;
    @(posedge i_mclk) disable iff (i_rst) o_lnk_cpl_auto |-> !$past(i_rd_data_valid);
  endproperty
  a_auto_quiet: assert property (p_auto_quiet) else $error("auto reply over user answer"); // R11

  // register number only moves when a request is taken
  property p_reg_hold;
    @(posedge i_mclk) disable iff (i_rst) !(rd_take || wr_take) |=> $stable(o_reg_num);
  endproperty
  a_reg_hold: assert property (p_reg_hold) else $error("register number moved"); // R06

  // a write outside both windows never reaches the user
  property p_wr_drop;
    @(posedge i_mclk) disable iff (i_rst) (i_lnk_wr_req && !reg_ext) |=> !o_wr_received;
  endproperty
  a_wr_drop: assert property (p_wr_drop) else $error("out of range write strobed"); // R02

  // write payload stays put between write strobes
  property p_wr_hold;
    @(posedge i_mclk) disable iff (i_rst) !(wr_take && !rd_take) |=>
      $stable(o_wr_data) && $stable(o_wr_be);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write payload moved"); // R09

  // reads outside the windows are still announced to the user
  property p_rd_any;
    @(posedge i_mclk) disable iff (i_rst) (rd_take && !reg_ext) |=> o_rd_received;
  endproperty
  a_rd_any: assert property (p_rd_any) else $error("out of range read not strobed"); // R01

  // no new read is taken while a read waits, though in-range writes still update the fields
  property p_rd_busy;
    @(posedge i_mclk) disable iff (i_rst) o_rd_received |-> !o_lnk_rd_ready;
  endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("ready during read strobe"); // R01

  // completions only ever answer a read that is waiting
  property p_cpl_idle;
    @(posedge i_mclk) disable iff (i_rst) (state_r != CXP_WAIT) |=> !o_lnk_cpl_valid;
  endproperty
  a_cpl_idle: assert property (p_cpl_idle) else $error("completion without a read"); // R10

  // one completion per read, never a repeat
  sequence s_cpl_once;
    o_lnk_cpl_valid ##1 !o_lnk_cpl_valid;
  endsequence
  property p_cpl_once;
    @(posedge i_mclk) disable iff (i_rst) o_lnk_cpl_valid |-> s_cpl_once;
  endproperty
  a_cpl_once: assert property (p_cpl_once) else $error("completion repeated"); // R11

  // wait counter never passes the limit while a read is pending
  property p_tmo_range;
    @(posedge i_mclk) disable iff (i_rst) (state_r == CXP_WAIT) |->
      (tmo_cnt_r <= CXP_TMO_W'(TIMEOUT_CYC - 1));
  endproperty
  a_tmo_range: assert property (p_tmo_range) else $error("wait counter past limit"); // R11

  // at the limit with no answer, the zero reply goes out
  property p_tmo_fire;
    @(posedge i_mclk) disable iff (i_rst)
      (state_r == CXP_WAIT && tmo_hit && !i_rd_data_valid) |=> o_lnk_cpl_auto;
  endproperty
  a_tmo_fire: assert property (p_tmo_fire) else $error("no auto reply at limit"); // R11

  ////////////////////////////////////////////////////////////////////////
  // cycles since the last read strobe; independent of the wait counter
  // so a broken counter cannot hide a late completion
  logic [CXP_TMO_W-1:0]  span_r;
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      span_r <= '0;
    else if (o_rd_received)
      span_r <= CXP_TMO_W'(1);
    else if (span_r != '0 && !o_lnk_cpl_valid)
      span_r <= span_r + 1'b1;
    else
      span_r <= '0;
  end

  // every completion lands within the limit counted from its strobe
  property p_cpl_bound;
    @(posedge i_mclk) disable iff (i_rst) o_lnk_cpl_valid |->
      (span_r != '0) && (span_r <= CXP_TMO_W'(TIMEOUT_CYC));
  endproperty
  a_cpl_bound: assert property (p_cpl_bound) else $error("completion later than limit"); // R11

endmodule // cxp_port
`default_nettype wire

// File: tb/cxp_user_model.sv
// Purpose: user-side register model answering extended config reads
// Assumes: read strobes from the port are one-cycle pulses
// Notes:   i_mute withholds an answer so the auto reply can be seen
`timescale 1ns/10ps
`default_nettype none
module cxp_user_model
  import cxp_pkg::*;
(
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst,
  input  wire logic                  i_rd_received,
  input  wire logic [CXP_REG_W-1:0]  i_reg_num,
  input  wire logic [CXP_FN_W-1:0]   i_fn_num,
  input  wire logic [2:0]            i_delay,
  input  wire logic                  i_mute,
  output logic [CXP_DATA_W-1:0]      o_rd_data,
  output logic                       o_rd_data_valid
);
  logic       pend_r;
  logic [2:0] cnt_r;
  ////////////////////////////////////////////////////////////////////////////////
  // one read held at a time; idle data toggles so a stale word never looks valid
  always_ff @(posedge i_mclk)
  begin
    o_rd_data_valid <= 1'b0;
    o_rd_data       <= i_rst ? 32'h0 : ~o_rd_data;
    if (i_rst)
      pend_r <= 1'b0;
    else if (i_rd_received)
    begin
      pend_r <= !i_mute && ((i_reg_num >= CXP_LEG_LO && i_reg_num <= CXP_LEG_HI)
                || (i_reg_num >= CXP_EXT_LO && i_reg_num <= CXP_EXT_HI));
      cnt_r  <= i_delay;
    end
    else if (pend_r && cnt_r != 3'h0)
      cnt_r <= cnt_r - 3'h1;
    else if (pend_r)
    begin
      pend_r          <= 1'b0;
      o_rd_data_valid <= 1'b1;
      o_rd_data       <= {i_fn_num, 8'ha5, 6'h00, i_reg_num};
    end
  end
endmodule // cxp_user_model
`default_nettype wire

// File: tb/tb.sv
// Purpose: self-checking bench for the config extend port
// Assumes: short response wait of 16 cycles
// Notes:   expected words are built from the range rules
`timescale 1ns/10ps
`default_nettype none
module tb;
  import cxp_pkg::*;
  logic        i_mclk, i_rst, en, rq, wq, mute, rdv, rrc, wrc, rdy, cv, ca;
  logic [9:0]  rg, org;
  logic [7:0]  fn, ofn;
  logic [31:0] wd, owd, rdd, cd, rv, seed;
  logic [3:0]  be, obe;
  logic [2:0]  dly;
  int          fail_count, cmp_count;
  logic [9:0]  edges [8] = '{10'h0af, 10'h0b0, 10'h0bf, 10'h0c0,
                             10'h11f, 10'h120, 10'h13f, 10'h140};
  cxp_port #(.TIMEOUT_CYC(16)) cxp_port_inst (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_ext_space_en(en), .i_lnk_rd_req(rq), .i_lnk_wr_req(wq), .i_lnk_reg_num(rg),
    .i_lnk_fn_num(fn), .i_lnk_wr_data(wd), .i_lnk_wr_be(be), .o_lnk_rd_ready(rdy),
    .o_lnk_cpl_valid(cv), .o_lnk_cpl_data(cd), .o_lnk_cpl_auto(ca), .o_rd_received(rrc),
    .o_wr_received(wrc), .o_reg_num(org), .o_fn_num(ofn), .o_wr_data(owd), .o_wr_be(obe),
    .i_rd_data(rdd), .i_rd_data_valid(rdv));
  cxp_user_model cxp_user_model_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_rd_received(rrc),
    .i_reg_num(org), .i_fn_num(ofn), .i_delay(dly), .i_mute(mute), .o_rd_data(rdd),
    .o_rd_data_valid(rdv));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic inr(input logic [9:0] r);
    return (r >= 10'h0b0 && r <= 10'h0bf) || (r >= 10'h120 && r <= 10'h13f);
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (e !== s)
    begin
      $display("mismatch %s exp %h got %h", n, e, s);
      fail_count++;
    end
  endtask
  task automatic summarize;
    if (fail_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // bounded wait on a design flag, a spent bound ends the run
  task automatic wait_for(input bit want_cpl);
    int n;
    n = 0;
    while ((want_cpl ? cv : rdy) !== 1'b1 && n < 100)
    begin
      @(negedge i_mclk);
      n++;
    end
    if (n >= 100)
    begin
      $display("mismatch wait_for exp 1 got 0");
      fail_count++;
      summarize;
    end
  endtask
  task automatic rd(input logic [9:0] r, input logic [7:0] f, input logic m);
    @(negedge i_mclk);
    rq   = 1'b1;
    rg   = r;
    fn   = f;
    mute = m;
    dly  = rv[22:20];
    @(negedge i_mclk);
    rq = 1'b0;
    chk("rd_rcv", 32'(en), 32'(rrc));
    if (en)
    begin
      chk("rd_reg", 32'(r), 32'(org));
      chk("rd_fn", 32'(f), 32'(ofn));
    end
    @(negedge i_mclk);
    chk("rd_pulse", 32'h0, 32'(rrc));
    if (en)
    begin
      wait_for(1'b1);
      chk("cpl_data", (inr(r) && !m) ? {f, 8'ha5, 6'h00, r} : 32'h0, cd);
      chk("cpl_auto", 32'(!(inr(r) && !m)), 32'(ca));
    end
    else
      chk("rd_cpl_off", 32'h0, 32'(cv));
    wait_for(1'b0);
  endtask
  task automatic wr(input logic [9:0] r);
    @(negedge i_mclk);
    wq = 1'b1;
    rg = r;
    fn = rv[17:10];
    wd = rnd();
    be = rv[3:0];
    @(negedge i_mclk);
    wq = 1'b0;
    chk("wr_rcv", 32'(inr(r) && en), 32'(wrc));
    if (inr(r) && en)
      chk("wr_fields", {wd[31:22] ^ r, fn, be, 10'h0}, {owd[31:22] ^ org, ofn, obe, 10'h0});
    if (inr(r) && en)
      chk("wr_data", wd, owd);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  initial
  begin
    {i_rst, en, rq, wq, mute, rg, fn, wd, be, dly, fail_count, cmp_count} = '0;
    i_rst = 1'b1;
    en    = 1'b1;
    seed  = 32'h5909e05d;
    repeat (5) @(negedge i_mclk);
    i_rst = 1'b0;
    for (int i = 0; i < 24; i++)
    begin
      rv = rnd();
      rg = (i % 12 < 8) ? edges[i % 8] : (rv[0] ? 10'h0b0 + 10'(rv[4:1]) : 10'h120 + 10'(rv[5:1]));
      if (i < 12)
        rd(rg, rv[17:10], i == 9 || i == 2);
      else
        wr(rg);
    end
    en = 1'b0;
    wr(10'h0b4);
    rd(10'h124, 8'h3c, 1'b0);
    summarize;
  end
endmodule // tb
`default_nettype wire
